/* rtl/rca_pkg.sv */
// Package for the calibration and alarm block: register map, fields, timing
package rca_pkg;

  // Register word offsets on the plain register port
  localparam logic [3:0] ADDR_CAL       = 4'h0;
  localparam logic [3:0] ADDR_ALM_CFG   = 4'h1;
  localparam logic [3:0] ADDR_ALM_MATCH = 4'h2;
  localparam logic [3:0] ADDR_CTRL      = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLR   = 4'h6;
  localparam logic [3:0] ADDR_TIME      = 4'h7;

  // Alarm configuration field positions
  localparam int ALM_EN_BIT    = 15;
  localparam int INDEFINITE_REPEAT_BIT     = 14;
  localparam int MASK_LSB      = 10;
  localparam int MASK_W        = 4;
  localparam int RPT_W         = 8;

  // Control register bit positions
  localparam int CTRL_TMR_ON   = 0;
  localparam int CTRL_SYNC     = 1;
  localparam int CTRL_WDAY_LSB = 4;

  // Interrupt status bit positions
  localparam int IRQ_ALARM     = 0;
  localparam int IRQ_CAL       = 1;
  localparam int IRQ_W         = 2;

  // Reset values and the indefinite-repeat reload count
  localparam logic [15:0] CAL_RST      = 16'h0000;
  localparam logic [15:0] ALM_CFG_RST  = 16'h0000;
  localparam logic [31:0] MATCH_RST    = 32'h0000_0000;
  localparam logic [7:0]  RPT_FULL     = 8'hFF;

  // Timing: 50 MHz system clock, 32768 Hz timebase
  localparam int CLK_HZ         = 50_000_000;
  localparam int XTAL_HZ        = 32_768;
  localparam int CAL_SCALE      = 4;
  localparam int TICKS_HALF_SEC = XTAL_HZ / 2;
  localparam int HALF_PER_MIN   = 120;
  localparam int SYNC_WINDOW    = 32;

  // Digit set compared by the alarm: BCD time of day and date
  typedef struct packed {
    logic [7:0] month_day;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rca_time_s;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } rca_req_s;

endpackage

/* rtl/rca_core.sv */
// Calibration and masked-digit alarm logic of the real-time calendar
// Overview of operation
// - Signed calibration times four, applied each minute
// - Alarm runs while enabled; hardware clears enable
// - Interval mask selects digits that must match
// - Zero repeat gives one alarm; FFh gives 256
// - Decrement count per alarm; final alarm disables
// - Indefinite repeat wraps count to FFh
// - Interrupt request on every alarm event
// - Alarm pulse output toggles each event
// - Intervals from half second to one month
//
// The implementer's own choices: strobed register access and the address map.
module rca_core #(
  parameter int TICKS_HALF_SEC = rca_pkg::TICKS_HALF_SEC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Timebase and calendar
  input  wire logic              xtal_tick,
  input  wire rca_pkg::rca_time_s cal_time,
  input  wire logic [2:0]        weekday,
  // Register port
  input  wire rca_pkg::rca_req_s reg_req,
  output logic [31:0]            rdata,
  // Outputs to the calendar and system
  output logic                   half_sec,
  output logic                   adj_valid,
  output logic signed [9:0]      adj_pulses,
  output logic                   alarm_pulse,
  output logic                   irq
);
  import rca_pkg::*;

  // Divider width follows the half-second count
  localparam int DIV_W = $clog2(TICKS_HALF_SEC + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICKS_HALF_SEC - 1);
  localparam logic [6:0] MIN_LAST = 7'(HALF_PER_MIN - 1);
  // Short dividers shrink the unsafe window so it never spans the whole half
  localparam int SYNC_TICKS = (TICKS_HALF_SEC > 4 * SYNC_WINDOW) ? SYNC_WINDOW
                                                                 : TICKS_HALF_SEC / 4;
  localparam logic [DIV_W-1:0] SYNC_FROM = DIV_W'(TICKS_HALF_SEC - 1 - SYNC_TICKS);

  logic [15:0]          calibration_register;
  logic [15:0]          alarm_config_register;
  rca_time_s            alarm_match_value;
  logic [2:0]           alarm_weekday;
  logic                 timer_on;
  logic [IRQ_W-1:0]     irq_stat;
  logic [IRQ_W-1:0]     irq_en;
  logic [DIV_W-1:0]     div_cnt;
  logic [6:0]           half_cnt;
  logic                 half_tick;
  logic                 minute_tick;
  logic                 alarm_event;
  logic                 match_prev;
  logic                 match_now;
  logic                 rollover_sync_flag;
  logic [IRQ_W-1:0]     irq_set;

  // Fields of the alarm configuration register
  wire logic alarm_enable        = alarm_config_register[ALM_EN_BIT];
  wire logic indefinite_repeat   = alarm_config_register[INDEFINITE_REPEAT_BIT];
  wire logic [MASK_W-1:0] alarm_interval_mask =
    alarm_config_register[MASK_LSB +: MASK_W];
  wire logic [RPT_W-1:0] alarm_repeat_count = alarm_config_register[RPT_W-1:0];

  // Write strobe decode shared by every writable register
  function automatic logic wr_hit(input rca_req_s r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Half-second divider on the crystal tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt   <= '0;
      half_tick <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      // Timer off parks the divider so a restart begins a full half second
      if (!timer_on) begin
        div_cnt <= '0;
      end else if (xtal_tick) begin
        if (div_cnt == DIV_LAST) begin
          div_cnt   <= '0;
          half_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 1'b1;
        end
      end
    end
  end

  // Minute counter for the periodic correction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt    <= '0;
      minute_tick <= 1'b0;
    end else begin
      minute_tick <= 1'b0;
      if (!timer_on) begin
        half_cnt <= '0;
      end else if (half_tick) begin
        if (half_cnt == MIN_LAST) begin
          half_cnt    <= '0;
          minute_tick <= 1'b1;
        end else begin
          half_cnt <= half_cnt + 1'b1;
        end
      end
    end
  end

  // Sync flag high near a rollover, where config edits are unsafe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rollover_sync_flag <= 1'b0;
    end else begin
      rollover_sync_flag <= timer_on && (div_cnt >= SYNC_FROM);
    end
  end

  // Correction handed to the calendar counter once a minute
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adj_valid  <= 1'b0;
      adj_pulses <= '0;
    end else begin
      adj_valid <= minute_tick && (calibration_register[7:0] != 8'h00);
      // Held until the next minute so the calendar may latch it late
      if (minute_tick) begin
        adj_pulses <= 10'(signed'(calibration_register[7:0]) * CAL_SCALE);
      end
    end
  end

  // Seconds square wave for the calendar
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_sec <= 1'b0;
    end else if (half_tick) begin
      half_sec <= ~half_sec;
    end
  end

  // Per-digit equality terms shared by the mask decode
  logic sec_ones_eq;
  logic sec_eq;
  logic min_ones_eq;
  logic min_eq;
  logic hour_eq;
  logic day_eq;
  logic wday_eq;

  assign sec_ones_eq = alarm_match_value.seconds[3:0] == cal_time.seconds[3:0];
  assign sec_eq      = alarm_match_value.seconds == cal_time.seconds;
  assign min_ones_eq = alarm_match_value.minutes[3:0] == cal_time.minutes[3:0];
  assign min_eq      = alarm_match_value.minutes == cal_time.minutes;
  assign hour_eq     = alarm_match_value.hours == cal_time.hours;
  assign day_eq      = alarm_match_value.month_day == cal_time.month_day;
  assign wday_eq     = alarm_weekday == weekday;

  // Mask code selects which digits must match; codes above 9 never fire
  always_comb begin
    unique case (alarm_interval_mask)
      4'h0:       match_now = 1'b1;
      4'h1:       match_now = 1'b1;
      4'h2:       match_now = sec_ones_eq;
      4'h3:       match_now = sec_eq;
      4'h4:       match_now = sec_eq && min_ones_eq;
      4'h5:       match_now = sec_eq && min_eq;
      4'h6:       match_now = sec_eq && min_eq && hour_eq;
      4'h7:       match_now = sec_eq && min_eq && hour_eq && wday_eq;
      4'h8, 4'h9: match_now = sec_eq && min_eq && hour_eq && day_eq;
      default:    match_now = 1'b0;
    endcase
  end

  // Half-second mask fires on every tick, every-second mask on each whole
  // second, coarser ones once per new match; the match history moves only
  // on whole seconds, so a match that starts mid-second is still caught
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_event <= 1'b0;
      match_prev  <= 1'b0;
    end else begin
      alarm_event <= 1'b0;
      if (half_tick) begin
        if (!half_sec) begin
          match_prev <= match_now;
        end
        alarm_event <= alarm_enable && match_now &&
                       ((alarm_interval_mask == 4'h0) ||
                        (!half_sec && ((alarm_interval_mask == 4'h1) ||
                                       !match_prev)));
      end
    end
  end

  // Alarm configuration; a write in the event cycle wins over the count update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_config_register <= ALM_CFG_RST;
    end else if (wr_hit(reg_req, ADDR_ALM_CFG)) begin
      alarm_config_register <= reg_req.wdata[15:0];
    end else if (alarm_event) begin
      if (alarm_repeat_count != 8'h00) begin
        alarm_config_register[RPT_W-1:0] <= alarm_repeat_count - 8'h01;
      end else if (indefinite_repeat) begin
        alarm_config_register[RPT_W-1:0] <= RPT_FULL;
      end else begin
        alarm_config_register[ALM_EN_BIT] <= 1'b0;
      end
    end
  end

  // Calibration, match and control writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calibration_register <= CAL_RST;
      alarm_match_value    <= MATCH_RST;
      alarm_weekday        <= '0;
      timer_on             <= 1'b0;
    end else begin
      if (wr_hit(reg_req, ADDR_CAL)) begin
        calibration_register <= reg_req.wdata[15:0];
      end
      if (wr_hit(reg_req, ADDR_ALM_MATCH)) begin
        alarm_match_value <= reg_req.wdata;
      end
      if (wr_hit(reg_req, ADDR_CTRL)) begin
        timer_on      <= reg_req.wdata[CTRL_TMR_ON];
        alarm_weekday <= reg_req.wdata[CTRL_WDAY_LSB +: 3];
      end
    end
  end

  // Alarm output runs at half the alarm rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_pulse <= 1'b0;
    end else if (alarm_event) begin
      alarm_pulse <= ~alarm_pulse;
    end
  end

  // Sticky status; a set in the clearing cycle wins
  assign irq_set = {adj_valid, alarm_event};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_en   <= '0;
    end else begin
      if (wr_hit(reg_req, ADDR_IRQ_EN)) begin
        irq_en <= reg_req.wdata[IRQ_W-1:0];
      end
      if (wr_hit(reg_req, ADDR_IRQ_CLR)) begin
        irq_stat <= (irq_stat & ~reg_req.wdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_en);
    end
  end

  // Read data in the cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_CAL:       rdata <= {16'h0000, calibration_register};
        ADDR_ALM_CFG:   rdata <= {16'h0000, alarm_config_register};
        ADDR_ALM_MATCH: rdata <= alarm_match_value;
        ADDR_CTRL:      rdata <= {25'h0, alarm_weekday, 2'h0,
                                  rollover_sync_flag, timer_on};
        ADDR_IRQ_STAT:  rdata <= {30'h0, irq_stat};
        ADDR_IRQ_EN:    rdata <= {30'h0, irq_en};
        ADDR_TIME:      rdata <= cal_time;
        default:        rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule

/* verification/rca_core_asserts.sv */
// Concurrent checks on the calibration and alarm block ports
module rca_core_asserts #(
  parameter int TICKS_HALF_SEC = 8
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // Inputs
  input wire logic               xtal_tick,
  input wire rca_pkg::rca_time_s cal_time,
  input wire logic [2:0]         weekday,
  input wire rca_pkg::rca_req_s  reg_req,
  // Outputs
  input wire logic [31:0]        rdata,
  input wire logic               half_sec,
  input wire logic               adj_valid,
  input wire logic signed [9:0]  adj_pulses,
  input wire logic               alarm_pulse,
  input wire logic               irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import rca_pkg::*;
  logic [15:0] cal_q;
  logic [15:0] cfg_q;
  logic [15:0] gap;
  logic [1:0]  en_q;
  logic        ap_q;
  wire         evt = alarm_pulse != ap_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_q <= '0;
      en_q  <= '0;
    end else if (reg_req.wr && reg_req.addr == ADDR_CAL) cal_q <= reg_req.wdata[15:0];
    else if (reg_req.wr && reg_req.addr == ADDR_IRQ_EN) en_q <= reg_req.wdata[1:0];
  end
  // Enable and count shadow, one cycle behind the block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
      ap_q  <= 1'b0;
    end else begin
      ap_q <= alarm_pulse;
      if (reg_req.wr && reg_req.addr == ADDR_ALM_CFG) cfg_q <= reg_req.wdata[15:0];
      else if (evt && cfg_q[7:0] != 8'h00) cfg_q[7:0] <= cfg_q[7:0] - 8'h01;
      else if (evt && cfg_q[INDEFINITE_REPEAT_BIT]) cfg_q[7:0] <= RPT_FULL;
      else if (evt) cfg_q[ALM_EN_BIT] <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) gap <= '0;
    else if ($changed(half_sec)) gap <= 16'h0001;
    else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
  end
  chk_adj_value: assert property (adj_valid |->
    adj_pulses == 10'($signed(cal_q[7:0]) * 4)) else $error("bad adjustment");
  chk_adj_nonzero: assert property (adj_valid |-> cal_q[7:0] != 8'h00)
    else $error("adjustment with zero calibration");
  chk_rd_idle: assert property (!$past(reg_req.rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  chk_alarm_enabled: assert property (evt |-> cfg_q[ALM_EN_BIT])
    else $error("alarm while disabled");
  chk_alarm_once: assert property (evt |=> !evt [*8])
    else $error("alarm events too close");
  chk_half_gap: assert property ($changed(half_sec) |-> gap >= TICKS_HALF_SEC)
    else $error("half second too short");
  chk_irq_event: assert property (evt && en_q[IRQ_ALARM] |-> ##[0:2] irq)
    else $error("no interrupt for alarm");
  chk_irq_cause: assert property ($rose(irq) |-> en_q != 2'b00)
    else $error("interrupt while masked");
  cover property (evt);
  cover property (adj_valid);
  cover property ($rose(irq));
endmodule

/* verification/rca_xtal_model.sv */
// Crystal timebase model: one tick each crystal period
module rca_xtal_model #(
  parameter int PERIOD = 4
) (
  // Clock, reset and tick
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      xtal_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Ideal rate; drift is left to software calibration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 0;
      xtal_tick <= 1'b0;
    end else begin
      cnt       <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      xtal_tick <= cnt == PERIOD - 1;
    end
  end
endmodule

/* verification/rca_core_tb.sv */
// Self-checking bench for the calibration and alarm block
module rca_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rca_pkg::*;
  logic              clk;
  logic              rst_n;
  logic              xtal_tick;
  rca_time_s         cal_time;
  rca_req_s          req;
  logic [31:0]       rdata;
  logic              half_sec, adj_valid, alarm_pulse, irq;
  logic              ap_d = 1'b0;
  logic signed [9:0] adj_pulses;
  logic [7:0]        cals [2] = '{8'h80, 8'h7F};
  int                n_errors = 0, n_tests = 0, n_evt = 0, n0, i;
  rca_xtal_model #(.PERIOD(4)) u_xtal (.clk(clk), .rst_n(rst_n), .xtal_tick(xtal_tick));
  rca_core #(.TICKS_HALF_SEC(8)) u_dut (.clk(clk), .rst_n(rst_n), .xtal_tick(xtal_tick),
    .cal_time(cal_time), .weekday(3'h0), .reg_req(req), .rdata(rdata),
    .half_sec(half_sec), .adj_valid(adj_valid), .adj_pulses(adj_pulses),
    .alarm_pulse(alarm_pulse), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    ap_d <= alarm_pulse;
    if (alarm_pulse !== ap_d) n_evt <= n_evt + 1;
  end
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{w, !w, a, d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rchk(input string s, input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
    acc(1'b0, a, 32'h0);
    check(s, rdata & m, e);
  endtask
  task automatic give_verdict;
    $display("Checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    cal_time = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk("cal reset", ADDR_CAL, 32'(CAL_RST));
    rchk("cfg reset", ADDR_ALM_CFG, 32'(ALM_CFG_RST));
    rchk("unmapped", 4'hC, 32'h0);
    // Signed limits, each written with the timer off
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, ADDR_CTRL, 32'h0);
      acc(1'b1, ADDR_CAL, {24'h0, cals[k]});
      acc(1'b1, ADDR_CTRL, 32'h1);
      for (i = 0; i < 5000 && adj_valid !== 1'b1; i++) begin
        @(posedge clk);
        #1;
      end
      check("adjust", 32'(adj_pulses), 32'($signed(cals[k]) * 4));
    end
    rchk("ctrl", ADDR_CTRL, 32'h1, 32'h1);
    acc(1'b1, ADDR_IRQ_EN, 32'h1);
    acc(1'b1, ADDR_ALM_MATCH, 32'h5);
    n0 = n_evt;
    acc(1'b1, ADDR_ALM_CFG, 32'h8002);
    repeat (400) @(posedge clk);
    check("repeats", 32'(n_evt - n0), 32'h3);
    rchk("cfg off", ADDR_ALM_CFG, 32'h0);
    rchk("status", ADDR_IRQ_STAT, 32'h1, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    acc(1'b1, ADDR_IRQ_CLR, 32'h3);
    rchk("status clr", ADDR_IRQ_STAT, 32'h0, 32'h1);
    rchk("clr reads 0", ADDR_IRQ_CLR, 32'h0);
    check("irq low", {31'h0, irq}, 32'h0);
    // Read just after an event so the count is settled
    n0 = n_evt;
    acc(1'b1, ADDR_ALM_CFG, 32'hC001);
    repeat (300) @(posedge clk);
    i = n_evt;
    for (int t = 0; t < 100 && n_evt == i; t++) @(posedge clk);
    rchk("indefinite_repeat", ADDR_ALM_CFG, 32'hC0FF - 32'(n_evt - n0 - 2));
    // Config edits wait until the rollover flag has come and gone
    i = 0;
    do begin
      acc(1'b0, ADDR_CTRL, 32'h0);
      i++;
    end while (i < 40 && rdata[CTRL_SYNC] !== 1'b1);
    check("sync high", {31'h0, rdata[CTRL_SYNC]}, 32'h1);
    i = 0;
    do begin
      acc(1'b0, ADDR_CTRL, 32'h0);
      i++;
    end while (i < 40 && rdata[CTRL_SYNC] !== 1'b0);
    check("sync low", {31'h0, rdata[CTRL_SYNC]}, 32'h0);
    acc(1'b1, ADDR_ALM_CFG, 32'h0);
    cal_time.seconds <= 8'h04;
    acc(1'b1, ADDR_ALM_CFG, 32'h8C00);
    n0 = n_evt;
    repeat (100) @(posedge clk);
    check("no match", 32'(n_evt - n0), 32'h0);
    cal_time.seconds <= 8'h05;
    repeat (200) @(posedge clk);
    check("one match", 32'(n_evt - n0), 32'h1);
    rchk("time", ADDR_TIME, 32'h0000_0005);
    rchk("single", ADDR_ALM_CFG, 32'h0C00);
    acc(1'b1, ADDR_ALM_CFG, 32'hBC00);
    n0 = n_evt;
    repeat (200) @(posedge clk);
    check("mask never", 32'(n_evt - n0), 32'h0);
    give_verdict();
  end
endmodule
bind rca_core rca_core_asserts #(.TICKS_HALF_SEC(TICKS_HALF_SEC)) u_chk (.clk(clk),
  .rst_n(rst_n), .xtal_tick(xtal_tick), .cal_time(cal_time), .weekday(weekday),
  .reg_req(reg_req), .rdata(rdata), .half_sec(half_sec), .adj_valid(adj_valid),
  .adj_pulses(adj_pulses), .alarm_pulse(alarm_pulse), .irq(irq));
